// ---- hdl/sync_ctrl_pkg.sv ----
// Purpose: constants for the output synchronisation control block
// Assumes: one clock, the VCO input clock, on ref_clk
// Notes: register map on a plain address/strobe port, 16-bit data
package sync_ctrl_pkg;
	localparam int        NUM_OUT        = 5;
	// register offsets
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_SYNC_EN   = 8'h04;
	localparam logic [7:0] ADDR_FDRV      = 8'h08;
	localparam logic [7:0] ADDR_STATUS    = 8'h0C;
	localparam logic [7:0] ADDR_OUT_BASE  = 8'h10;
	localparam logic [7:0] ADDR_OUT_STEP  = 8'h04;
	// field positions
	localparam int        CTRL_MODE_LSB  = 0;
	localparam int        CTRL_PDN_BIT   = 2;
	localparam int        OUT_MOD_LSB    = 0;
	localparam int        OUT_DEL_LSB    = 8;
	localparam int        STAT_BUSY_BIT  = 0;
	localparam int        STAT_HELD_LSB  = 1;
	// reset values
	localparam logic [1:0] RST_MODE       = 2'h1;
	localparam logic       RST_PDN        = 1'b0;
	localparam logic [4:0] RST_SYNC_EN    = 5'h00;
	localparam logic [4:0] RST_FDRV       = 5'h00;
	localparam logic [5:0] RST_MOD        = 6'h04;
	localparam logic [5:0] RST_DEL        = 6'h00;
	// mode codes
	localparam logic [1:0] MODE_CONTROL   = 2'h0;
	localparam logic [1:0] MODE_STANDALONE = 2'h1;
	// timing counts in VCO cycles
	localparam logic [6:0] LAT_STANDALONE = 7'h06;
	localparam logic [6:0] LAT_FSYNC      = 7'h3E;
	localparam logic [6:0] LAT_FOLLOW     = 7'h07;
	localparam logic [6:0] FDRV_BASE      = 7'h06;
	localparam logic [6:0] FDRV_STEP      = 7'h07;
	localparam logic [5:0] FDRV_MAX_MOD   = 6'h08;
	localparam logic [6:0] CNT_LAST       = 7'h7F;

	typedef enum logic [1:0] {S_IDLE, S_GATE, S_WAITN, S_COUNT} sync_state_t;
endpackage : sync_ctrl_pkg

// ---- hdl/edge_sampler.sv ----
// Purpose: registers sync and N divider levels and flags both sync edges and the N divider rise
// Assumes: both inputs synchronous to ref_clk
// Notes: pulses are one cycle wide, one cycle after the edge
`timescale 1ns/1ps
`default_nettype none
module edge_sampler
	import sync_ctrl_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic syncIn,
	input  wire logic nDivider,
	output var  logic syncRise,
	output var  logic syncFall,
	output var  logic nRise
);
	logic syncPrev;
	logic nPrev;

	// previous levels
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			syncPrev <= 1'b0;
			nPrev    <= 1'b0;
		end
		else
		begin
			syncPrev <= syncIn;
			nPrev    <= nDivider;
		end
	end

	// edge pulses
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			syncRise <= 1'b0;
			syncFall <= 1'b0;
			nRise    <= 1'b0;
		end
		else
		begin
			syncRise <= syncIn & ~syncPrev;
			syncFall <= ~syncIn & syncPrev;
			nRise    <= nDivider & ~nPrev;
		end
	end
endmodule : edge_sampler
`default_nettype wire

// ---- hdl/output_channel.sv ----
// Purpose: one divided output with runt-free gating and timed restart
// Assumes: modulus already clamped by the caller
// Notes: moduli 0 and 1 run with a two-cycle period here
`timescale 1ns/1ps
`default_nettype none
module output_channel
	import sync_ctrl_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic [5:0] modulus,
	input  wire logic       syncEnable,
	input  wire logic       gate,
	input  wire logic       restart,
	output var  logic       clkOut,
	output var  logic       held
);
	logic [5:0] count;
	logic [5:0] period;
	logic [5:0] half;
	logic [5:0] next_count;
	logic       next_level;

	// divider period and high time
	assign period     = (modulus < 6'h02) ? 6'h02 : modulus;
	assign half       = 6'((period + 6'h01) >> 1);
	assign next_count = (count >= period - 6'h01) ? 6'h00 : count + 6'h01;
	assign next_level = next_count < half;

	// divider, gating and restart
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count  <= 6'h00;
			clkOut <= 1'b0;
			held   <= 1'b0;
		end
		else if (!syncEnable)
		begin
			held   <= 1'b0;
			count  <= next_count;
			clkOut <= next_level;
		end
		else if (restart)
		begin
			held   <= 1'b0;
			count  <= 6'h00;
			clkOut <= 1'b1;
		end
		else if (held)
		begin
			count  <= 6'h00;
			clkOut <= 1'b0;
		end
		else if (gate && !next_level)
		begin
			held   <= 1'b1;
			count  <= 6'h00;
			clkOut <= 1'b0;
		end
		else
		begin
			count  <= next_count;
			clkOut <= next_level;
		end
	end
endmodule : output_channel
`default_nettype wire

// ---- hdl/multichip_output_sync_control.sv ----
// Purpose: sync sequencer, register file and five synchronised outputs
// Assumes: ref_clk is the VCO input clock; sync and N divider are synchronous
// Notes: release times are counted from the N divider edge or the sync fall
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module multichip_output_sync_control
	import sync_ctrl_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire logic [7:0]           busAddr,
	input  wire logic [15:0]          busWrData,
	input  wire logic                 busWrite,
	input  wire logic                 busRead,
	output var  logic [15:0]          busRdData,
	input  wire logic                 syncIn,
	input  wire logic                 nDivider,
	output wire logic [NUM_OUT-1:0]   clkOut,
	output var  logic                 syncBusy
);
	logic [1:0]         syncMode;
	logic               pllPowerDown;
	logic [NUM_OUT-1:0] outputSyncEnable;
	logic [NUM_OUT-1:0] followerDriveSelect;
	logic [5:0]         outputDivideModulus [NUM_OUT];
	logic [5:0]         outputCycleDelay    [NUM_OUT];
	logic [5:0]         effModulus          [NUM_OUT];
	logic [6:0]         releaseAt           [NUM_OUT];
	logic [NUM_OUT-1:0] restart;
	logic [NUM_OUT-1:0] heldVec;
	logic [15:0]        next_rdData;
	logic [6:0]         refCount;
	logic               syncRise;
	logic               syncFall;
	logic               nRise;
	logic               retimeToN;
	logic               isControl;
	sync_state_t        state;

	// address of an output's configuration word
	function automatic logic [7:0] out_cfg_addr(input int idx);
		return ADDR_OUT_BASE + 8'(idx * int'(ADDR_OUT_STEP));
	endfunction : out_cfg_addr

	// driver detection: the select bit counts only in controller mode
	function automatic logic is_driver(input logic [1:0] mode, input logic fdrv);
		return (mode == MODE_CONTROL) && fdrv;
	endfunction : is_driver

	// divider modulus actually used by an output
	function automatic logic [5:0] eff_mod(input logic driver, input logic [5:0] mod);
		logic [5:0] m;
		m = (mod == 6'h00) ? 6'h01 : mod;
		if (driver && m > FDRV_MAX_MOD)
			m = FDRV_MAX_MOD;
		return m;
	endfunction : eff_mod

	// cycle, counted from the reference point, of an output's first rise
	function automatic logic [6:0] release_cycle(input logic [1:0] mode, input logic driver,
		input logic [5:0] mod, input logic [5:0] del);
		logic [6:0] base;
		logic [6:0] m7;
		m7 = {1'b0, eff_mod(driver, mod)};
		if (mode[1])
			base = LAT_FOLLOW;
		else if (mode == MODE_STANDALONE)
			base = LAT_STANDALONE;
		else if (driver)
			base = FDRV_BASE + 7'(FDRV_STEP * ({1'b0, FDRV_MAX_MOD} - m7));
		else
			base = LAT_FSYNC;
		if (driver)
			return base;
		return base + {1'b0, del};
	endfunction : release_cycle

	assign isControl = (syncMode == MODE_CONTROL);
	// N divider retiming only with a running PLL, never for a follower
	assign retimeToN = !syncMode[1] && !pllPowerDown;

	// global configuration writes
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			syncMode            <= RST_MODE;
			pllPowerDown        <= RST_PDN;
			outputSyncEnable    <= RST_SYNC_EN;
			followerDriveSelect <= RST_FDRV;
		end
		else if (busWrite)
		begin
			if (busAddr == ADDR_CTRL)
			begin
				syncMode     <= busWrData[CTRL_MODE_LSB +: 2];
				pllPowerDown <= busWrData[CTRL_PDN_BIT];
			end
			if (busAddr == ADDR_SYNC_EN)
				outputSyncEnable <= busWrData[NUM_OUT-1:0];
			if (busAddr == ADDR_FDRV)
				followerDriveSelect <= busWrData[NUM_OUT-1:0];
		end
	end

	// per-output configuration, release times and channels
	for (genvar i = 0; i < NUM_OUT; i++)
	begin : g_out
		always_ff @(posedge ref_clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				outputDivideModulus[i] <= RST_MOD;
				outputCycleDelay[i]    <= RST_DEL;
			end
			else if (busWrite && busAddr == out_cfg_addr(i))
			begin
				outputDivideModulus[i] <= busWrData[OUT_MOD_LSB +: 6];
				outputCycleDelay[i]    <= busWrData[OUT_DEL_LSB +: 6];
			end
		end

		assign effModulus[i] = eff_mod(is_driver(syncMode, followerDriveSelect[i]), outputDivideModulus[i]);
		assign releaseAt[i]  = release_cycle(syncMode, is_driver(syncMode, followerDriveSelect[i]),
			outputDivideModulus[i], outputCycleDelay[i]);
		// restart exactly on the counted cycle
		assign restart[i]    = (state == S_COUNT) && (refCount == releaseAt[i]);

		output_channel u_chan (
			.ref_clk    (ref_clk),
			.arst_n     (arst_n),
			.modulus    (effModulus[i]),
			.syncEnable (outputSyncEnable[i]),
			.gate       (state == S_GATE),
			.restart    (restart[i]),
			.clkOut     (clkOut[i]),
			.held       (heldVec[i])
		);
	end

	edge_sampler u_edges (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.syncIn   (syncIn),
		.nDivider (nDivider),
		.syncRise (syncRise),
		.syncFall (syncFall),
		.nRise    (nRise)
	);

	// sync sequencer
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			state <= S_IDLE;
		else
		begin
			unique case (state)
				S_IDLE:  if (syncRise) state <= S_GATE;
				S_GATE:  if (syncFall) state <= retimeToN ? S_WAITN : S_COUNT;
				S_WAITN: if (nRise) state <= S_COUNT;
				S_COUNT: if (refCount == CNT_LAST) state <= S_IDLE;
			endcase
		end
	end

	// cycle counter from the reference point
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			refCount <= 7'h00;
		else if (state == S_COUNT)
			refCount <= refCount + 7'h01;
		else
			refCount <= 7'h00;
	end

	// busy flag
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			syncBusy <= 1'b0;
		else
			syncBusy <= (state != S_IDLE);
	end

	// read multiplexer
	always_comb
	begin
		next_rdData = 16'h0000;
		unique case (busAddr)
			ADDR_CTRL:    next_rdData = 16'({pllPowerDown, syncMode});
			ADDR_SYNC_EN: next_rdData = 16'(outputSyncEnable);
			ADDR_FDRV:    next_rdData = 16'(followerDriveSelect);
			ADDR_STATUS:  next_rdData = 16'({heldVec, syncBusy});
			default:      next_rdData = 16'h0000;
		endcase
		for (int k = 0; k < NUM_OUT; k++)
			if (busAddr == out_cfg_addr(k))
				next_rdData = {2'h0, outputCycleDelay[k], 2'h0, outputDivideModulus[k]};
	end

	// read data, valid the cycle after the strobe
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			busRdData <= 16'h0000;
		else if (busRead)
			busRdData <= next_rdData;
		else
			busRdData <= 16'h0000;
	end

	// checks on the sequencer and release timing
	property p_undisturbed;
		@(posedge ref_clk) disable iff (!arst_n)
		(heldVec & ~$past(outputSyncEnable)) == '0;
	endproperty
	a_undisturbed: assert property (p_undisturbed) else $error("disabled output was gated");

	property p_retime_path;
		@(posedge ref_clk) disable iff (!arst_n)
		(state == S_GATE && syncFall) |=> ((state == S_WAITN) == (!syncMode[1] && !pllPowerDown));
	endproperty
	a_retime_path: assert property (p_retime_path) else $error("wrong retime path");

	property p_follow_no_n;
		@(posedge ref_clk) disable iff (!arst_n)
		syncMode[1] |-> state != S_WAITN;
	endproperty
	a_follow_no_n: assert property (p_follow_no_n) else $error("follower waited on N");

	property p_n_reference;
		@(posedge ref_clk) disable iff (!arst_n)
		(state == S_WAITN && nRise) |=> (state == S_COUNT && refCount == 7'h00);
	endproperty
	a_n_reference: assert property (p_n_reference) else $error("count not started at N edge");

	property p_standalone_lat;
		@(posedge ref_clk) disable iff (!arst_n)
		(syncMode == MODE_STANDALONE) |-> releaseAt[0] == LAT_STANDALONE + {1'b0, outputCycleDelay[0]};
	endproperty
	a_standalone_lat: assert property (p_standalone_lat) else $error("standalone latency wrong");

	property p_fsync_lat;
		@(posedge ref_clk) disable iff (!arst_n)
		(isControl && !followerDriveSelect[1]) |-> releaseAt[1] == LAT_FSYNC + {1'b0, outputCycleDelay[1]};
	endproperty
	a_fsync_lat: assert property (p_fsync_lat) else $error("follower-sync latency wrong");

	property p_driver_nodelay;
		@(posedge ref_clk) disable iff (!arst_n)
		(isControl && followerDriveSelect[2] && $changed(outputCycleDelay[2]) && $stable(outputDivideModulus[2]))
			|-> $stable(releaseAt[2]);
	endproperty
	a_driver_nodelay: assert property (p_driver_nodelay) else $error("driver used its delay");

	property p_clamp;
		@(posedge ref_clk) disable iff (!arst_n)
		(isControl && followerDriveSelect[3] && outputDivideModulus[3] > FDRV_MAX_MOD)
			|-> effModulus[3] == FDRV_MAX_MOD;
	endproperty
	a_clamp: assert property (p_clamp) else $error("driver modulus not clamped");

	property p_no_clamp;
		@(posedge ref_clk) disable iff (!arst_n)
		(syncMode[1] && outputDivideModulus[4] != 6'h00) |-> effModulus[4] == outputDivideModulus[4];
	endproperty
	a_no_clamp: assert property (p_no_clamp) else $error("modulus limited outside driver");

	property p_held_low;
		@(posedge ref_clk) disable iff (!arst_n)
		(heldVec[0] && !$past(restart[0])) |-> !clkOut[0];
	endproperty
	a_held_low: assert property (p_held_low) else $error("held output not low");

	property p_count_bounded;
		@(posedge ref_clk) disable iff (!arst_n)
		$rose(state == S_COUNT) |-> ##[1:130] (state == S_IDLE);
	endproperty
	a_count_bounded: assert property (p_count_bounded) else $error("count phase overran");

	property p_follow_lat;
		@(posedge ref_clk) disable iff (!arst_n)
		syncMode[1] |-> releaseAt[3] == LAT_FOLLOW + {1'b0, outputCycleDelay[3]};
	endproperty
	a_follow_lat: assert property (p_follow_lat) else $error("follower latency wrong");

	property p_count_from_fall;
		@(posedge ref_clk) disable iff (!arst_n)
		(state == S_GATE && syncFall && !retimeToN) |=> (state == S_COUNT && refCount == 7'h00);
	endproperty
	a_count_from_fall: assert property (p_count_from_fall) else $error("count not started at sync fall");

	property p_all_drivers;
		@(posedge ref_clk) disable iff (!arst_n)
		(isControl && (&followerDriveSelect))
			|-> releaseAt[0] == FDRV_BASE + 7'(FDRV_STEP * ({1'b0, FDRV_MAX_MOD} - {1'b0, effModulus[0]}));
	endproperty
	a_all_drivers: assert property (p_all_drivers) else $error("driver timing lost with five drivers");

	property p_restart_rise;
		@(posedge ref_clk) disable iff (!arst_n)
		(restart[0] && outputSyncEnable[0]) |=> clkOut[0];
	endproperty
	a_restart_rise: assert property (p_restart_rise) else $error("output did not rise on release");
endmodule : multichip_output_sync_control
`default_nettype wire

// ---- tb/follower_model.sv ----
// Purpose: behavioural follower device fed by a gated driver clock
// Assumes: driver clock sampled on ref_clk
// Notes: follows its input clock once seven input cycles have passed
`timescale 1ns/1ps
`default_nettype none
module follower_model
(
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic syncIn,
	input  wire logic vcoIn,
	output wire logic folOut
);
	logic       prevIn;
	logic [2:0] riseCnt;
	logic       opened;

	// count input rises after sync falls, never waiting on an N divider
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prevIn  <= 1'b0;
			riseCnt <= 3'h0;
			opened  <= 1'b0;
		end
		else
		begin
			prevIn <= vcoIn;
			if (syncIn)
			begin
				riseCnt <= 3'h0;
				opened  <= 1'b0;
			end
			else if (vcoIn && !prevIn && riseCnt != 3'h7)
				riseCnt <= riseCnt + 3'h1;
			// open only once the seventh input cycle has ended low
			if (!syncIn && riseCnt == 3'h7 && !vcoIn)
				opened <= 1'b1;
		end
	end

	// output held low for seven input cycles, first rise on the eighth
	assign folOut = opened & vcoIn;
endmodule : follower_model
`default_nettype wire

// ---- tb/multichip_output_sync_control_test.sv ----
// Purpose: bench for the output sync control block
// Assumes: N divider modelled as ref_clk divided by 8
// Notes: first rising edges compared as offsets between modes
`timescale 1ns/1ps
`default_nettype none
module multichip_output_sync_control_test
	import sync_ctrl_pkg::*;
;
	logic        ref_clk, arst_n, syncIn, nDivider, busWrite, busRead, nRun, syncBusy, folOut;
	logic [7:0]  busAddr;
	logic [15:0] busWrData, busRdData;
	logic [4:0]  clkOut, prevOut;
	logic [2:0]  nCnt;
	int          cyc, sFall, base, folFirst, mismatches, nChecks;
	int          firstRise[5], togCnt[5];
	logic [15:0] cfg[5] = '{16'h0004, 16'h0504, 16'h0314, 16'h0001, 16'h0200};
	int          expC[5] = '{56, 28, 0, 49, 49};

	multichip_output_sync_control dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .busAddr(busAddr),
		.busWrData(busWrData), .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData),
		.syncIn(syncIn), .nDivider(nDivider), .clkOut(clkOut), .syncBusy(syncBusy));

	follower_model fol_u (.ref_clk(ref_clk), .arst_n(arst_n), .syncIn(syncIn), .vcoIn(clkOut[1]),
		.folOut(folOut));

	// clock
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// N divider stimulus and edge bookkeeping
	always @(posedge ref_clk)
	begin
		cyc      <= cyc + 1;
		nCnt     <= nCnt + 3'h1;
		nDivider <= nRun & ~nCnt[2];
		prevOut  <= clkOut;
		for (int i = 0; i < 5; i++)
		begin
			if (clkOut[i] === 1'b1 && prevOut[i] === 1'b0 && firstRise[i] < 0)
				firstRise[i] <= cyc;
			if (syncIn && clkOut[i] !== prevOut[i])
				togCnt[i] <= togCnt[i] + 1;
		end
		if (folOut === 1'b1 && folFirst < 0)
			folFirst <= cyc;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nChecks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task wrapUp;
		if (mismatches == 0 && nChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrapUp

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		busAddr   <= a;
		busWrData <= d;
		busWrite  <= 1'b1;
		@(posedge ref_clk);
		busWrite  <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		busAddr <= a;
		busRead <= 1'b1;
		@(posedge ref_clk);
		busRead <= 1'b0;
		@(posedge ref_clk);
		check(busRdData, exp);
	endtask : rd

	function automatic logic [7:0] outA(input int i);
		return ADDR_OUT_BASE + ADDR_OUT_STEP * 8'(i);
	endfunction : outA

	function automatic int off(input int i);
		return firstRise[i] - sFall;
	endfunction : off

	function automatic logic allUp(input logic [4:0] m);
		allUp = 1'b1;
		for (int i = 0; i < 5; i++)
			if (m[i] && firstRise[i] < 0)
				allUp = 1'b0;
	endfunction : allUp

	// sync pulse, dropped four cycles ahead of an N rise, then wait for release
	task automatic doSync(input logic [4:0] mask);
		int k;
		togCnt = '{default:0};
		@(posedge ref_clk);
		syncIn <= 1'b1;
		repeat (24) @(posedge ref_clk);
		rd(ADDR_STATUS, 16'({mask, 1'b1}));
		for (k = 0; k < 20 && nCnt !== 3'h4; k++)
			@(posedge ref_clk);
		syncIn    <= 1'b0;
		sFall     = cyc;
		firstRise = '{default:-1};
		folFirst  = -1;
		for (k = 0; k < 400; k++)
		begin
			@(posedge ref_clk);
			if (syncBusy === 1'b0 && allUp(mask))
				break;
		end
		if (k == 400)
		begin
			mismatches++;
			wrapUp();
		end
	endtask : doSync

	// main sequence
	initial
	begin
		arst_n = 1'b0;
		syncIn = 1'b0;
		busWrite = 1'b0;
		busRead = 1'b0;
		busAddr = 8'h00;
		busWrData = 16'h0000;
		nRun = 1'b1;
		nDivider = 1'b0;
		nCnt = 3'h0;
		cyc = 0;
		mismatches = 0;
		nChecks = 0;
		folFirst = -1;
		firstRise = '{default:-1};
		togCnt = '{default:0};
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(ADDR_CTRL, 16'h0001);
		rd(ADDR_SYNC_EN, 16'h0000);
		rd(ADDR_FDRV, 16'h0000);
		rd(ADDR_OUT_BASE, 16'h0004);
		rd(8'h40, 16'h0000);
		// standalone with driver bits set, out1 one cycle late
		wr(ADDR_SYNC_EN, 16'h0003);
		wr(ADDR_FDRV, 16'h001F);
		wr(outA(1), 16'h0104);
		doSync(5'h03);
		base = off(0);
		check(16'(off(1) - base), 16'h0001);
		check(16'(togCnt[2] > 10), 16'h0001);
		rd(ADDR_STATUS, 16'h0000);
		// controller: out0 follower-synchronous, four drivers
		wr(ADDR_CTRL, 16'h0000);
		wr(ADDR_SYNC_EN, 16'h001F);
		wr(ADDR_FDRV, 16'h001E);
		for (int i = 0; i < 5; i++)
		begin
			wr(outA(i), cfg[i]);
			rd(outA(i), cfg[i]);
		end
		doSync(5'h1F);
		for (int i = 0; i < 5; i++)
			check(16'(off(i) - base), 16'(expC[i]));
		check(16'(folFirst - firstRise[0]), 16'h0000);
		// all five as drivers, out2 delay changed alone
		wr(outA(2), 16'h3F14);
		wr(ADDR_FDRV, 16'h001F);
		doSync(5'h1F);
		check(16'(off(0) - base), 16'h001C);
		check(16'(off(2) - base), 16'h0000);
		// standalone, PLL down, N divider stopped
		wr(ADDR_CTRL, 16'h0005);
		nRun <= 1'b0;
		doSync(5'h1F);
		check(16'(off(0) + 4 - base), 16'h0000);
		check(16'(off(1) - off(0)), 16'h0005);
		nRun <= 1'b1;
		// follower modes with N running, PLL up then down
		for (int m = 0; m < 2; m++)
		begin
			wr(ADDR_CTRL, (m == 1) ? 16'h0007 : 16'h0002);
			doSync(5'h1F);
			check(16'(off(0) + 3 - base), 16'h0000);
			check(16'(off(1) - off(0)), 16'h0005);
		end
		wrapUp();
	end
endmodule : multichip_output_sync_control_test
`default_nettype wire
